// file: design/i2a_pkg.sv
// Shared constants and types of the i2c address and scl rate slice
package i2a_pkg;

    localparam int unsigned NUM_SLOTS = 3;

    // Register indices; the byte address is four times the index
    localparam logic [NUM_SLOTS-1:0][31:0] IDX_OWN_LOW  =
        {32'h0008830E, 32'h0008830C, 32'h0008830A};
    localparam logic [NUM_SLOTS-1:0][31:0] IDX_OWN_HIGH =
        {32'h0008830F, 32'h0008830D, 32'h0008830B};
    localparam logic [31:0] IDX_SCL_LOW  = 32'h00088310;
    localparam logic [31:0] IDX_SCL_HIGH = 32'h00088311;
    localparam logic [31:0] IDX_SLV_EN   = 32'h00088320;
    localparam logic [31:0] IDX_MODE_ONE = 32'h00088321;
    localparam logic [31:0] IDX_FUNC_EN  = 32'h00088322;
    localparam logic [31:0] IDX_STATUS   = 32'h00088323;
    localparam logic [1:0]  ADR_LSB_ZERO = 2'h0;

    // Field layout
    localparam int unsigned LOW_LSB_BIT   = 0;
    localparam int unsigned HIGH_FS_BIT   = 0;
    localparam int unsigned HIGH_UP_LSB   = 1;
    localparam int unsigned FUNC_MST_BIT  = 0;
    localparam int unsigned FUNC_NFE_BIT  = 1;
    localparam int unsigned FUNC_NF_LSB   = 2;
    localparam int unsigned ST_SCL_BIT    = 3;
    localparam int unsigned ST_SHORT_STD  = 4;
    localparam int unsigned ST_SHORT_FAST = 5;
    localparam int unsigned ST_GEN_LSB    = 8;

    // Reset values and fixed read values
    localparam logic [7:0] OWN_LOW_RST   = 8'h00;
    localparam logic [2:0] OWN_HIGH_RST  = 3'h0;
    localparam logic [4:0] PERIOD_RST    = 5'h1F;
    localparam logic [2:0] PERIOD_RSV    = 3'h7;
    localparam logic [4:0] HIGH_RSV      = 5'h00;
    localparam logic [2:0] CKS_UNDIV     = 3'h0;
    localparam logic [3:0] FUNC_RST      = 4'h0;

    // Reference divider and state run counter widths
    localparam int unsigned DIV_W = 7;
    localparam int unsigned RUN_W = 13;

    // Data setup times and their pclk counts, rounded up
    localparam int unsigned PCLK_MHZ      = 100;
    localparam int unsigned STD_SETUP_NS  = 250;
    localparam int unsigned FAST_SETUP_NS = 100;
    localparam logic [RUN_W-1:0] STD_SETUP_CYC  =
        RUN_W'((STD_SETUP_NS * PCLK_MHZ + 999) / 1000);
    localparam logic [RUN_W-1:0] FAST_SETUP_CYC =
        RUN_W'((FAST_SETUP_NS * PCLK_MHZ + 999) / 1000);

    // SCL generator states
    typedef enum logic [5:0] {
        GEN_IDLE    = 6'b000001,
        GEN_LOW     = 6'b000010,
        GEN_WAIT_HI = 6'b000100,
        GEN_HIGH    = 6'b001000,
        GEN_HOLD    = 6'b010000,
        GEN_SETUP   = 6'b100000
    } i2a_gen_t;

endpackage

// file: design/i2a_ref_div.sv
// Reference clock divider producing the count tick for scl periods
`timescale 1ns/100ps
module i2a_ref_div
    import i2a_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] cks,
    input  wire logic       restart,
    output logic            tick
);
    logic [DIV_W-1:0] div_cnt_reg;
    logic [DIV_W-1:0] limit;

    // Division by two to the power of the select code; zero is undivided
    assign limit = DIV_W'((8'h01 << cks) - 8'h01);   // [RULE9] [RULE14]
    assign tick  = (div_cnt_reg >= limit);   // A lowered select wraps at once

    // Phase counter, realigned when a new period starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= '0;
        end else if (restart || tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end
endmodule

// file: design/i2a_addr_match.sv
// Own-address comparator over all slots at once
`timescale 1ns/100ps
module i2a_addr_match
    import i2a_pkg::*;
(
    input  wire logic [NUM_SLOTS-1:0]      slot_en,
    input  wire logic [NUM_SLOTS-1:0]      fmt_ten,
    input  wire logic [NUM_SLOTS-1:0][7:0] low_byte,
    input  wire logic [NUM_SLOTS-1:0][1:0] upper_bits,
    input  wire logic [9:0]                rx_addr,
    input  wire logic                      rx_ten,
    output logic      [NUM_SLOTS-1:0]      match
);
    // One comparator per slot, all evaluated in parallel
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_cmp
        logic seven_hit;
        logic ten_hit;
        // Seven-bit form ignores the lsb and the upper bits
        assign seven_hit = !rx_ten &&
            (rx_addr[6:0] == low_byte[g][7:1]);             // [RULE2]
        // Ten-bit form joins upper bits, seven-bit field and lsb
        assign ten_hit = rx_ten &&
            (rx_addr == {upper_bits[g], low_byte[g]});      // [RULE3]
        // Disabled slot never matches, whatever its fields
        assign match[g] = slot_en[g] &&
            (fmt_ten[g] ? ten_hit : seven_hit);   // [RULE4] [RULE16]
    end
endmodule

// file: design/i2a_top.sv
// Own-address slots and scl bit-rate generator with APB registers
// Function
// RULE1 - Three own-address slots, each a low byte and a high byte register.
// RULE2 - Enabled slot, seven-bit format: compare seven-bit field only.
// RULE3 - Enabled slot, ten-bit format: upper bits, seven-bit field, lsb.
// RULE4 - Disabled slot ignores all its address fields and format bit.
// RULE5 - Reserved high-byte bits read zero; software writes zero.
// RULE6 - Five-bit low setting sets scl low time in reference ticks.
// RULE7 - Five-bit high setting sets scl high time in reference ticks.
// RULE8 - Reserved period-register bits read one; software writes ones.
// RULE9 - Both periods count the divided reference clock chosen by select.
// RULE10 - Bit period is high plus one plus low plus one ticks, plus edges.
// RULE11 - High setting applies only in master use.
// RULE12 - Low setting also times data setup of automatic low-hold.
// RULE13 - With noise filter, settings exceed filter stage count by one; no filter is built, func_reg bits 1 to 3 are only stored.
// RULE14 - Select code zero gives the undivided peripheral clock.
// RULE15 - Master counts high time only after seeing scl really high.
// RULE16 - Received address is compared against all enabled slots at once.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module i2a_top
    import i2a_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 serial_clock_line_in,
    output logic                      serial_clock_line_out,
    output logic                      serial_clock_line_oe_n,
    input  wire logic                 hold_request,
    output logic                      setup_active,
    input  wire logic                 link_clk,
    input  wire logic [9:0]           rx_addr,
    input  wire logic                 rx_ten,
    input  wire logic                 rx_valid,
    output logic                      link_busy,
    output logic      [NUM_SLOTS-1:0] match_flags,
    output logic                      match_valid
);
    // Register storage
    logic [NUM_SLOTS-1:0][7:0] own_low_reg;
    logic [NUM_SLOTS-1:0][2:0] own_high_reg;
    logic [4:0]                low_count_reg;
    logic [4:0]                high_count_reg;
    logic [NUM_SLOTS-1:0]      slot_en_reg;
    logic [2:0]                cks_reg;
    logic [3:0]                func_reg;
    // Bus side
    logic        wr_en;
    logic        rd_setup;
    logic [31:0] rdata_next;
    logic        err_next;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    // Generator
    i2a_gen_t         state_reg;
    i2a_gen_t         state_next;
    logic [4:0]       cnt_reg;
    logic             ref_tick;
    logic             restart;
    logic             master_en;
    logic             drive_low;
    logic             scl_oe_n_reg;
    logic             setup_active_reg;
    logic [RUN_W-1:0] run_cnt_reg;
    logic [RUN_W-1:0] low_span;
    // Pin synchroniser
    logic scl_s1_reg;
    logic scl_s2_reg;
    logic scl_s3_reg;
    logic scl_lvl_reg;
    // Link crossing
    logic       lk_req_tog_reg;
    logic [9:0] lk_addr_reg;
    logic       lk_ten_reg;
    logic       lk_ack_s1_reg;
    logic       lk_ack_s2_reg;
    logic       lk_ack_s3_reg;
    logic       lk_ack_lvl_reg;
    logic       lk_busy_reg;
    logic       req_s1_reg;
    logic       req_s2_reg;
    logic       req_s3_reg;
    logic       req_lvl_reg;
    logic       req_event;
    logic [NUM_SLOTS-1:0] match_vec;
    logic [NUM_SLOTS-1:0] match_reg;
    logic                 match_valid_reg;
    logic [NUM_SLOTS-1:0] fmt_ten;
    logic [NUM_SLOTS-1:0][1:0] upper_bits;

    // APB strobes: reads are prepared in setup, writes act in access
    assign rd_setup = psel && !penable;
    assign wr_en    = psel && penable && pwrite && pready_reg;

    // Per-slot address registers, one pair per slot
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                own_low_reg[g]  <= OWN_LOW_RST;
                own_high_reg[g] <= OWN_HIGH_RST;
            end else if (wr_en) begin
                if (paddr == {IDX_OWN_LOW[g][29:0], ADR_LSB_ZERO}) begin
                    own_low_reg[g] <= pwdata[7:0];              // [RULE1]
                end
                if (paddr == {IDX_OWN_HIGH[g][29:0], ADR_LSB_ZERO}) begin
                    own_high_reg[g] <= pwdata[2:0];       // [RULE1] [RULE5]
                end
            end
        end
        assign fmt_ten[g]    = own_high_reg[g][HIGH_FS_BIT];
        assign upper_bits[g] = own_high_reg[g][HIGH_UP_LSB +: 2];
    end

    // Period, enable, divider select and function registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_count_reg  <= PERIOD_RST;
            high_count_reg <= PERIOD_RST;
            slot_en_reg    <= '0;
            cks_reg        <= CKS_UNDIV;
            func_reg       <= FUNC_RST;
        end else if (wr_en) begin
            if (paddr == {IDX_SCL_LOW[29:0], ADR_LSB_ZERO}) begin
                low_count_reg <= pwdata[4:0];                   // [RULE6]
            end
            if (paddr == {IDX_SCL_HIGH[29:0], ADR_LSB_ZERO}) begin
                high_count_reg <= pwdata[4:0];                  // [RULE7]
            end
            if (paddr == {IDX_SLV_EN[29:0], ADR_LSB_ZERO}) begin
                slot_en_reg <= pwdata[NUM_SLOTS-1:0];
            end
            if (paddr == {IDX_MODE_ONE[29:0], ADR_LSB_ZERO}) begin
                cks_reg <= pwdata[2:0];                         // [RULE9]
            end
            if (paddr == {IDX_FUNC_EN[29:0], ADR_LSB_ZERO}) begin
                func_reg <= pwdata[3:0];
            end
        end
    end

    assign master_en = func_reg[FUNC_MST_BIT];
    assign low_span  = (RUN_W'(low_count_reg) + 1'b1) << cks_reg;

    // Read multiplexer and unmapped-address error
    always_comb begin
        rdata_next = '0;
        err_next   = 1'b0;
        if (paddr == {IDX_SCL_LOW[29:0], ADR_LSB_ZERO}) begin
            rdata_next[7:0] = {PERIOD_RSV, low_count_reg};      // [RULE8]
        end else if (paddr == {IDX_SCL_HIGH[29:0], ADR_LSB_ZERO}) begin
            rdata_next[7:0] = {PERIOD_RSV, high_count_reg};     // [RULE8]
        end else if (paddr == {IDX_SLV_EN[29:0], ADR_LSB_ZERO}) begin
            rdata_next[NUM_SLOTS-1:0] = slot_en_reg;
        end else if (paddr == {IDX_MODE_ONE[29:0], ADR_LSB_ZERO}) begin
            rdata_next[2:0] = cks_reg;
        end else if (paddr == {IDX_FUNC_EN[29:0], ADR_LSB_ZERO}) begin
            rdata_next[3:0] = func_reg;
        end else if (paddr == {IDX_STATUS[29:0], ADR_LSB_ZERO}) begin
            rdata_next[NUM_SLOTS-1:0]     = match_reg;
            rdata_next[ST_SCL_BIT]        = scl_lvl_reg;
            rdata_next[ST_SHORT_STD]      = low_span < STD_SETUP_CYC;
            rdata_next[ST_SHORT_FAST]     = low_span < FAST_SETUP_CYC;
            rdata_next[ST_GEN_LSB +: 6]   = state_reg;
        end else begin
            err_next = 1'b1;
        end
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (paddr == {IDX_OWN_LOW[i][29:0], ADR_LSB_ZERO}) begin
                rdata_next[7:0] = own_low_reg[i];
                err_next        = 1'b0;
            end
            if (paddr == {IDX_OWN_HIGH[i][29:0], ADR_LSB_ZERO}) begin
                rdata_next[7:0] = {HIGH_RSV, own_high_reg[i]};  // [RULE5]
                err_next        = 1'b0;
            end
        end
    end

    // Answer registers: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (rd_setup) begin
            prdata_reg  <= pwrite ? '0 : rdata_next;
            pready_reg  <= 1'b1;
            pslverr_reg <= err_next;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // SCL pin synchroniser; level changes once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_s1_reg  <= 1'b1;
            scl_s2_reg  <= 1'b1;
            scl_s3_reg  <= 1'b1;
            scl_lvl_reg <= 1'b1;
        end else begin
            scl_s1_reg <= serial_clock_line_in;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            if (scl_s2_reg == scl_s3_reg) begin
                scl_lvl_reg <= scl_s3_reg;
            end
        end
    end

    i2a_ref_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .cks     (cks_reg),
        .restart (restart),
        .tick    (ref_tick)
    );

    // Generator next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            GEN_IDLE: begin
                if (master_en && scl_lvl_reg) begin
                    state_next = GEN_LOW;
                end else if (!master_en && hold_request && !scl_lvl_reg) begin
                    state_next = GEN_HOLD;
                end
            end
            GEN_LOW: begin
                if (ref_tick && cnt_reg == low_count_reg) begin // [RULE10]
                    state_next = GEN_WAIT_HI;
                end
            end
            GEN_WAIT_HI: begin
                if (!master_en) begin
                    state_next = GEN_IDLE;                      // [RULE11]
                end else if (scl_lvl_reg) begin
                    state_next = GEN_HIGH;                      // [RULE15]
                end
            end
            GEN_HIGH: begin
                if (!master_en) begin
                    state_next = GEN_IDLE;                      // [RULE11]
                end else if (ref_tick && cnt_reg == high_count_reg) begin
                    state_next = GEN_LOW;                 // [RULE7] [RULE10]
                end
            end
            GEN_HOLD: begin
                if (!hold_request) begin
                    state_next = GEN_SETUP;
                end
            end
            GEN_SETUP: begin
                if (ref_tick && cnt_reg == low_count_reg) begin // [RULE12]
                    state_next = GEN_IDLE;
                end
            end
            default: begin
                state_next = GEN_IDLE;
            end
        endcase
    end

    assign restart   = (state_next != state_reg);
    assign drive_low = (state_next == GEN_LOW) || (state_next == GEN_HOLD) ||
                       (state_next == GEN_SETUP);

    // Generator state and reference tick counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= GEN_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (restart) begin
                cnt_reg <= '0;
            end else if (ref_tick) begin
                cnt_reg <= cnt_reg + 1'b1;                      // [RULE6]
            end
        end
    end

    // Open-drain drive: enable low only while pulling scl down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe_n_reg     <= 1'b1;
            setup_active_reg <= 1'b0;
        end else begin
            scl_oe_n_reg     <= !drive_low;
            setup_active_reg <= (state_next == GEN_SETUP);      // [RULE12]
        end
    end

    // Cycles spent in the current generator state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt_reg <= RUN_W'(1);
        end else if (restart) begin
            run_cnt_reg <= RUN_W'(1);
        end else begin
            run_cnt_reg <= run_cnt_reg + 1'b1;
        end
    end

    // Link side: take an address only when the previous one was acknowledged
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lk_req_tog_reg <= 1'b0;
            lk_addr_reg    <= '0;
            lk_ten_reg     <= 1'b0;
            lk_ack_s1_reg  <= 1'b0;
            lk_ack_s2_reg  <= 1'b0;
            lk_ack_s3_reg  <= 1'b0;
            lk_ack_lvl_reg <= 1'b0;
            lk_busy_reg    <= 1'b0;
        end else begin
            lk_ack_s1_reg <= req_lvl_reg;
            lk_ack_s2_reg <= lk_ack_s1_reg;
            lk_ack_s3_reg <= lk_ack_s2_reg;
            if (lk_ack_s2_reg == lk_ack_s3_reg) begin
                lk_ack_lvl_reg <= lk_ack_s3_reg;
            end
            if (rx_valid && !lk_busy_reg) begin
                lk_addr_reg    <= rx_addr;
                lk_ten_reg     <= rx_ten;
                lk_req_tog_reg <= !lk_req_tog_reg;
                lk_busy_reg    <= 1'b1;
            end else begin
                lk_busy_reg <= (lk_req_tog_reg != lk_ack_lvl_reg);
            end
        end
    end

    // Peripheral side of the request toggle
    assign req_event = (req_s2_reg == req_s3_reg) &&
                       (req_s3_reg != req_lvl_reg);

    i2a_addr_match u_match (
        .slot_en    (slot_en_reg),
        .fmt_ten    (fmt_ten),
        .low_byte   (own_low_reg),
        .upper_bits (upper_bits),
        .rx_addr    (lk_addr_reg),
        .rx_ten     (lk_ten_reg),
        .match      (match_vec)
    );

    // Capture match result while the link holds its address steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_s1_reg      <= 1'b0;
            req_s2_reg      <= 1'b0;
            req_s3_reg      <= 1'b0;
            req_lvl_reg     <= 1'b0;
            match_reg       <= '0;
            match_valid_reg <= 1'b0;
        end else begin
            req_s1_reg      <= lk_req_tog_reg;
            req_s2_reg      <= req_s1_reg;
            req_s3_reg      <= req_s2_reg;
            match_valid_reg <= req_event;
            if (req_event) begin
                req_lvl_reg <= req_s3_reg;
                match_reg   <= match_vec;                       // [RULE16]
            end
        end
    end

    assign prdata                 = prdata_reg;
    assign pready                 = pready_reg;
    assign pslverr                = pslverr_reg;
    assign serial_clock_line_out  = 1'b0;
    assign serial_clock_line_oe_n = scl_oe_n_reg;
    assign setup_active           = setup_active_reg;
    assign link_busy              = lk_busy_reg;
    assign match_flags            = match_reg;
    assign match_valid            = match_valid_reg;

    // Checks on the peripheral clock
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_low_read;
        rd_setup && !pwrite && paddr == {IDX_SCL_LOW[29:0], ADR_LSB_ZERO};
    endsequence
    sequence s_high0_read;
        rd_setup && !pwrite &&
            paddr == {IDX_OWN_HIGH[0][29:0], ADR_LSB_ZERO};
    endsequence

    a_period_rsv_ones: assert property (s_low_read |=> pready && // [RULE8]
        prdata[7:5] == PERIOD_RSV)
        else $error("period reserved bits not read as one");
    a_high_rsv_zero: assert property (s_high0_read |=> pready && // [RULE5]
        prdata[7:3] == HIGH_RSV)
        else $error("address reserved bits not read as zero");
    a_slot_disabled: assert property (match_valid_reg |-> // [RULE4]
        (match_reg & ~$past(slot_en_reg)) == '0)
        else $error("disabled slot reported a match");
    a_ten_bit_form: assert property (match_valid_reg && // [RULE3]
        match_reg[1] && $past(fmt_ten[1]) |-> $past(lk_ten_reg) &&
        $past(lk_addr_reg) == $past({upper_bits[1], own_low_reg[1]}))
        else $error("ten-bit match with wrong address");
    a_low_length: assert property (state_reg == GEN_LOW && // [RULE10]
        state_next != GEN_LOW |-> run_cnt_reg == low_span)
        else $error("scl low period length wrong");
    a_setup_length: assert property (state_reg == GEN_SETUP && // [RULE12]
        state_next != GEN_SETUP |-> run_cnt_reg == low_span)
        else $error("data setup interval length wrong");
    a_high_after_scl: assert property ($rose(state_reg == GEN_HIGH) // [RULE15]
        |-> $past(scl_lvl_reg))
        else $error("high count began with scl low");
    a_slave_no_high: assert property (!master_en && // [RULE11]
        state_reg == GEN_WAIT_HI |=> state_reg == GEN_IDLE)
        else $error("high period used without master mode");
    a_undivided_tick: assert property (cks_reg == CKS_UNDIV // [RULE14]
        |-> ref_tick)
        else $error("undivided reference missed a tick");
    a_low_drives: assert property (state_reg == GEN_LOW // [RULE6]
        |-> !serial_clock_line_oe_n)
        else $error("scl not driven during low period");
endmodule

// file: bench/i2a_bus_partner.sv
// Scl line model: pull-up with another device able to pull low
`timescale 1ns/100ps
module i2a_bus_partner (
    input  wire logic oe_n,
    input  wire logic pull,
    output logic      scl
);
    // Wired-and of the open-drain drivers, high when all release
    assign scl = !(!oe_n || pull);
endmodule

// file: bench/test_i2a_top.sv
// Self-checking bench for own-address slots and scl rate generator
`timescale 1ns/100ps
module test_i2a_top;
    import i2a_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        link_clk = 0, rx_ten = 0, rx_valid = 0, pull = 0, hold = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic [9:0]  rx_addr = 0;
    logic        pready, pslverr, scl, scl_o, oe_n, setup_act, link_busy, mv;
    logic [2:0]  mf;
    logic [6:0]  r7;
    logic [32:0] rq[$];
    int          lq[$];
    int          mismatches = 0, check_count = 0, cyc = 0, lc = 0, sc = 0;

    // Clocks of the two domains, unrelated in phase
    initial forever #5 pclk = ~pclk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    i2a_top i2a_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_line_in(scl), .serial_clock_line_out(scl_o),
        .serial_clock_line_oe_n(oe_n), .hold_request(hold),
        .setup_active(setup_act), .link_clk(link_clk), .rx_addr(rx_addr),
        .rx_ten(rx_ten), .rx_valid(rx_valid), .link_busy(link_busy),
        .match_flags(mf), .match_valid(mv));
    i2a_bus_partner i2a_bus_partner_inst (.oe_n(oe_n), .pull(pull), .scl(scl));

    task chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Watcher: read data, match results and scl low lengths
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            report_and_stop;
        end
        if (psel && penable && pready && !pwrite) begin
            chk({pslverr, prdata}, rq.pop_front());
        end
        if (mv) chk({30'h0, mf}, rq.pop_front());
        // Setup interval after a low-hold, measured in pclk cycles
        if (setup_act) sc++;
        else begin
            if (sc > 0) chk(33'(sc), rq.pop_front());
            sc = 0;
        end
        if (!oe_n) lc++;
        else begin
            if (lc > 0 && lq.size() > 0) chk(33'(lc), 33'(lq.pop_front()));
            lc = 0;
        end
    end

    task drain;
        while (rq.size() > 0 || lq.size() > 0) begin
            @(posedge pclk);
        end
    endtask

    task apb(input logic w, input logic [31:0] idx, d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= idx << 2;
        pwdata <= d;
        if (!w) rq.push_back(e);
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (!pready);
        psel <= 0;
        penable <= 0;
    endtask

    task link(input logic [9:0] a, input logic t, input logic [2:0] e);
        @(posedge link_clk);
        while (link_busy) begin
            @(posedge link_clk);
        end
        rx_addr <= a;
        rx_ten <= t;
        rx_valid <= 1;
        rq.push_back({30'h0, e});
        @(posedge link_clk);
        rx_valid <= 0;
        drain;
    endtask

    initial begin
        void'($urandom(99032));
        r7 = 7'($urandom());
        repeat (16) @(posedge pclk);
        presetn <= 1;
        // Reset values and reserved bits
        for (int s = 0; s < 3; s++) begin
            apb(0, IDX_OWN_LOW[s], 0, 33'h0);
            apb(1, IDX_OWN_HIGH[s], 32'h7, 0);
            apb(0, IDX_OWN_HIGH[s], 0, 33'h7);
        end
        apb(0, IDX_SCL_LOW, 0, 33'hFF);
        apb(0, IDX_SCL_HIGH, 0, 33'hFF);
        apb(0, 32'h00088330, 0, 33'h100000000);
        // Slot 0 seven-bit, slot 1 ten-bit, slot 2 disabled at first
        apb(1, IDX_OWN_LOW[0], 32'({r7, 1'b1}), 0);
        apb(1, IDX_OWN_HIGH[0], 32'h6, 0);
        apb(1, IDX_OWN_LOW[1], 32'h5A, 0);
        apb(1, IDX_OWN_HIGH[1], 32'h5, 0);
        apb(1, IDX_OWN_LOW[2], 32'({r7, 1'b0}), 0);
        apb(1, IDX_OWN_HIGH[2], 32'h0, 0);
        apb(1, IDX_SLV_EN, 32'h3, 0);
        link({3'h0, r7}, 0, 3'b001);
        link(10'h25A, 1, 3'b010);
        link(10'h05A, 1, 3'b000);
        apb(1, IDX_SLV_EN, 32'h7, 0);
        link({3'h0, r7}, 0, 3'b101);
        // Master low phase length for divider selects 0 to 2
        for (int c = 0; c < 3; c++) begin
            apb(1, IDX_MODE_ONE, c, 0);
            apb(1, IDX_SCL_LOW, 32'hE0 | (c + 2), 0);
            apb(1, IDX_SCL_HIGH, 32'hE1, 0);
            lq.push_back((c + 3) << c);
            lq.push_back((c + 3) << c);
            apb(1, IDX_FUNC_EN, 32'h1, 0); // filter left off
            drain;
            apb(1, IDX_FUNC_EN, 32'h0, 0);
            @(posedge pclk);
            while (!oe_n) begin
                @(posedge pclk);
            end
        end
        // Slave low-hold: another device pulls scl low, then lets go
        apb(1, IDX_SCL_LOW, 32'hE7, 0); // 320 ns setup
        pull <= 1;
        hold <= 1;
        repeat (8) @(posedge pclk);
        rq.push_back(33'h20);
        pull <= 0;
        hold <= 0;
        drain;
        report_and_stop;
    end

    task report_and_stop;
        mismatches += rq.size() + lq.size();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
endmodule
